// ---- eeprom_pkg.sv ----
package eeprom_pkg;

	// ------------------------------------------------------------
	// instruction field widths
	// ------------------------------------------------------------
	localparam int START_BITS    = 1;
	localparam int OPCODE_BITS   = 2;
	localparam int ADDR_BITS_X8  = 9;
	localparam int ADDR_BITS_X16 = 8;
	localparam int DATA_BITS_X8  = 8;
	localparam int DATA_BITS_X16 = 16;

	// ------------------------------------------------------------
	// exact clock pulse counts, start bit to chip select fall
	// ------------------------------------------------------------
	localparam int WRITE_PULSES_X8  = START_BITS + OPCODE_BITS + ADDR_BITS_X8 + DATA_BITS_X8;
	localparam int WRITE_PULSES_X16 = START_BITS + OPCODE_BITS + ADDR_BITS_X16 + DATA_BITS_X16;
	localparam int CTRL_PULSES_X8   = START_BITS + OPCODE_BITS + ADDR_BITS_X8;
	localparam int CTRL_PULSES_X16  = START_BITS + OPCODE_BITS + ADDR_BITS_X16;

	// ------------------------------------------------------------
	// capture widths
	// ------------------------------------------------------------
	localparam int SHIFT_BITS  = OPCODE_BITS + ADDR_BITS_X16 + DATA_BITS_X16;
	localparam int COUNT_BITS  = 6;
	localparam int WORD_BITS   = DATA_BITS_X16;
	localparam int WORD_INDEX_BITS = ADDR_BITS_X16;

	// ------------------------------------------------------------
	// opcodes and sub-codes of opcode 00
	// ------------------------------------------------------------
	localparam logic [1:0] OP_CTRL  = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ  = 2'h2;
	localparam logic [1:0] OP_ERASE = 2'h3;

	localparam logic [1:0] SUB_DISABLE   = 2'h0;
	localparam logic [1:0] SUB_FILL      = 2'h1;
	localparam logic [1:0] SUB_ERASE_ALL = 2'h2;
	localparam logic [1:0] SUB_ENABLE    = 2'h3;

	// ------------------------------------------------------------
	// array contents and timing
	// ------------------------------------------------------------
	localparam logic [15:0] ERASED_WORD = 16'hffff;
	localparam logic [7:0]  ERASED_BYTE = 8'hff;

	localparam int SYS_CLK_PERIOD_NS = 25;
	localparam int NS_PER_US         = 1000;

	typedef enum logic {
		PROG_IDLE,
		PROG_BUSY
	} prog_state_t;

endpackage : eeprom_pkg

// ---- eeprom_serial_front.sv ----
`timescale 1ns/1ps

module eeprom_serial_front
	import eeprom_pkg::*;
(
	// serial link, master's clock domain
	input  wire logic                  link_clk,
	input  wire logic                  cs,
	input  wire logic                  d,
	// captured frame, quasi-static once chip select falls
	// no reset reaches this side; the toggle only needs a known start
	output logic                       start_toggle = 1'b0,
	output logic [COUNT_BITS-1:0]      pulse_count,
	output logic [SHIFT_BITS-1:0]      shift_data
);

	logic started;

	// ------------------------------------------------------------
	// start bit detection
	// ------------------------------------------------------------
	// the link clock may stop after the last bit, so the frame's own
	// chip select ends it; count and data survive for the system side
	// busy is judged on the system side: this clock stops between frames
	wire start_seen = cs && !started && d;
	wire counting   = cs && started;
	wire [COUNT_BITS-1:0] count_inc = (pulse_count == {COUNT_BITS{1'b1}})
		? pulse_count : pulse_count + COUNT_BITS'(1);

	always_ff @(posedge link_clk or negedge cs)
	begin
		if (!cs)
			started <= 1'b0;
		else if (start_seen)
			started <= 1'b1;
	end

	always_ff @(posedge link_clk)
	begin
		if (start_seen)
		begin
			start_toggle <= !start_toggle;
			pulse_count  <= COUNT_BITS'(START_BITS);
			shift_data   <= '0;
		end
		else if (counting)
		begin
			pulse_count <= count_inc;
			shift_data  <= {shift_data[SHIFT_BITS-2:0], d};
		end
	end

endmodule : eeprom_serial_front

// ---- eeprom_fill_status_pulse_guard.sv ----
`timescale 1ns/1ps

// Functional notes
// - A fill-all instruction programs its data value into every array location.
// - While programming runs, raising chip select shows a low serial output (busy).
// - Serial input bits are ignored while a programming cycle is in progress; here a start up to two cycles before busy ends is kept.
// - When programming ends and chip select is high, the serial output goes high (ready).
// - Ready stays high until a new start bit is decoded or chip select falls.
// - Ready/busy is shown after every write, erase, fill-all and erase-all instruction.
// - Clock pulses are counted from the start bit to the fall of chip select.
// - A byte-wide write runs only on exactly 20 pulses, otherwise memory is untouched.
// - A word-wide write runs only on exactly 27 pulses, otherwise it is discarded.
// - Write, erase, erase-all and fill-all all require their exact pulse count.
// - The array starts all ones, both in word and in byte view.
// - Erase-all sets every bit to one, with the same self-timed cycle as erase.
// - Fill-all is start 1, opcode 00, address beginning 01 then don't-cares, then data.

module eeprom_fill_status_pulse_guard
	import eeprom_pkg::*;
#(
	parameter int WORDS        = 256,
	parameter int PROG_TIME_US = 1000,
	parameter int PROG_CYCLES  = (PROG_TIME_US * NS_PER_US + SYS_CLK_PERIOD_NS - 1)
		/ SYS_CLK_PERIOD_NS
)
(
	// system clock and reset
	input  wire logic sys_clk,
	input  wire logic srst,
	// serial link from the master
	input  wire logic link_clk,
	input  wire logic cs,
	input  wire logic d,
	output logic      q,
	output logic      q_oe,
	// organisation strap: 1 word, 0 byte
	input  wire logic org,
	// status
	output logic      busy,
	output logic      write_enabled
);

	localparam int TIMER_BITS = $clog2(PROG_CYCLES + 1);

	// ------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------
	if (WORDS != (1 << WORD_INDEX_BITS))
	begin : g_bad_words
		$error("WORDS must match the word address width");
	end
	if (PROG_CYCLES < 1)
	begin : g_bad_prog
		$error("PROG_CYCLES must be at least one");
	end

	// ------------------------------------------------------------
	// link-side capture
	// ------------------------------------------------------------
	logic                  start_toggle;
	logic [COUNT_BITS-1:0] pulse_count;
	logic [SHIFT_BITS-1:0] shift_data;

	eeprom_serial_front u_front (
		.link_clk     (link_clk),
		.cs           (cs),
		.d            (d),
		.start_toggle (start_toggle),
		.pulse_count  (pulse_count),
		.shift_data   (shift_data)
	);

	// ------------------------------------------------------------
	// synchronisers into sys_clk
	// ------------------------------------------------------------
	logic cs_meta;
	logic cs_sync;
	logic cs_prev;
	logic org_meta;
	logic org_sync;
	logic tog_meta;
	logic tog_sync;
	logic tog_seen;
	logic start_busy;

	always_ff @(posedge sys_clk)
	begin
		cs_meta  <= cs;
		cs_sync  <= cs_meta;
		org_meta <= org;
		org_sync <= org_meta;
		tog_meta <= start_toggle;
		tog_sync <= tog_meta;
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
			cs_prev <= 1'b0;
		else
			cs_prev <= cs_sync;
	end

	wire cs_fall    = cs_prev && !cs_sync;
	wire new_start  = tog_sync != tog_seen;
	wire frame_done = cs_fall && new_start;

	always_ff @(posedge sys_clk)
	begin
		if (srst)
			tog_seen <= tog_sync;
		else if (frame_done)
			tog_seen <= tog_sync;
	end

	// ------------------------------------------------------------
	// frame decode
	// ------------------------------------------------------------
	// left-justify the bits after the start bit so that every field sits
	// at a fixed place; only meaningful when the count already matched
	function automatic logic [SHIFT_BITS-1:0] align_frame(
		input logic [SHIFT_BITS-1:0] sh,
		input logic [COUNT_BITS-1:0] n
	);
		int amount;
		amount = SHIFT_BITS + START_BITS - int'(n);
		if (n == '0 || amount < 0)
			return sh;
		return sh << amount;
	endfunction : align_frame

	wire [SHIFT_BITS-1:0] aligned = align_frame(shift_data, pulse_count);

	wire [1:0]               op        = aligned[SHIFT_BITS-1 -: OPCODE_BITS];
	wire [1:0]               sub       = aligned[SHIFT_BITS-OPCODE_BITS-1 -: 2];
	wire [ADDR_BITS_X8-1:0]  addr_x8   = aligned[SHIFT_BITS-OPCODE_BITS-1 -: ADDR_BITS_X8];
	wire [DATA_BITS_X8-1:0]  data_x8   =
		aligned[SHIFT_BITS-OPCODE_BITS-ADDR_BITS_X8-1 -: DATA_BITS_X8];
	wire [DATA_BITS_X16-1:0] data_x16  =
		aligned[SHIFT_BITS-OPCODE_BITS-ADDR_BITS_X16-1 -: DATA_BITS_X16];
	wire [WORD_INDEX_BITS-1:0] word_idx = addr_x8[ADDR_BITS_X8-1 -: WORD_INDEX_BITS];
	wire                     high_byte = addr_x8[0];

	wire [COUNT_BITS-1:0] need_write = org_sync ? COUNT_BITS'(WRITE_PULSES_X16)
		: COUNT_BITS'(WRITE_PULSES_X8);
	wire [COUNT_BITS-1:0] need_ctrl  = org_sync ? COUNT_BITS'(CTRL_PULSES_X16)
		: COUNT_BITS'(CTRL_PULSES_X8);
	wire len_write = pulse_count == need_write;
	wire len_ctrl  = pulse_count == need_ctrl;

	wire do_write     = op == OP_WRITE && len_write;
	wire do_erase     = op == OP_ERASE && len_ctrl;
	wire do_fill      = op == OP_CTRL && sub == SUB_FILL && len_write;
	wire do_erase_all = op == OP_CTRL && sub == SUB_ERASE_ALL && len_ctrl;
	wire do_enable    = op == OP_CTRL && sub == SUB_ENABLE && len_ctrl;
	wire do_disable   = op == OP_CTRL && sub == SUB_DISABLE && len_ctrl;

	// ------------------------------------------------------------
	// programming sequencer
	// ------------------------------------------------------------
	prog_state_t           state;
	logic [TIMER_BITS-1:0] timer;

	wire idle       = state == PROG_IDLE;
	wire frame_take = frame_done && idle && !start_busy;
	wire prog_any   = do_write || do_erase || do_fill || do_erase_all;
	wire prog_go    = frame_take && write_enabled && prog_any;
	wire timer_end = timer == '0;

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			state <= PROG_IDLE;
			timer <= '0;
		end
		else
		begin
			case (state)
				PROG_IDLE:
				begin
					if (prog_go)
					begin
						state <= PROG_BUSY;
						timer <= TIMER_BITS'(PROG_CYCLES - 1);
					end
				end
				PROG_BUSY:
				begin
					if (timer_end)
						state <= PROG_IDLE;
					else
						timer <= timer - TIMER_BITS'(1);
				end
				default:
					state <= PROG_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// frames that began during programming
	// ------------------------------------------------------------
	// the link clock stands still between frames, so the link side cannot
	// know the busy level at a start bit; the start is judged here instead.
	// limitation: a start up to two cycles before busy ends is kept,
	// while a frame begun in busy is refused even if busy ends mid-frame
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			start_busy <= 1'b0;
		else if (frame_done)
			start_busy <= 1'b0;
		else if (new_start && !idle)
			start_busy <= 1'b1;
	end

	// erase/write enable latch; powers up disabled so noise cannot program
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			write_enabled <= 1'b0;
		else if (frame_take && do_enable)
			write_enabled <= 1'b1;
		else if (frame_take && do_disable)
			write_enabled <= 1'b0;
	end

	// ------------------------------------------------------------
	// memory array
	// ------------------------------------------------------------
	logic [WORD_BITS-1:0] mem [WORDS];

	wire [WORD_BITS-1:0] old_word = mem[word_idx];
	wire [WORD_BITS-1:0] byte_word = high_byte ? {data_x8, old_word[7:0]}
		: {old_word[15:8], data_x8};
	wire [WORD_BITS-1:0] erase_word = org_sync ? ERASED_WORD
		: (high_byte ? {ERASED_BYTE, old_word[7:0]} : {old_word[15:8], ERASED_BYTE});
	wire [WORD_BITS-1:0] single_word = do_erase ? erase_word
		: (org_sync ? data_x16 : byte_word);
	wire [WORD_BITS-1:0] all_word = do_erase_all ? ERASED_WORD
		: (org_sync ? data_x16 : {data_x8, data_x8});
	wire whole_array = do_fill || do_erase_all;

	always_ff @(posedge sys_clk)
	begin
		for (int i = 0; i < WORDS; i++)
		begin
			if (srst)
				mem[i] <= ERASED_WORD;
			else if (prog_go && whole_array)
				mem[i] <= all_word;
			else if (prog_go && !whole_array && word_idx == WORD_INDEX_BITS'(i))
				mem[i] <= single_word;
		end
	end

	// ------------------------------------------------------------
	// ready/busy on the serial output
	// ------------------------------------------------------------
	logic status_pending;
	logic ready_shown;

	wire show_ready = idle && cs_sync && status_pending;
	wire drop_ready = ready_shown && (!cs_sync || new_start);

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			status_pending <= 1'b0;
			ready_shown    <= 1'b0;
		end
		else if (prog_go)
		begin
			status_pending <= 1'b1;
			ready_shown    <= 1'b0;
		end
		else if (drop_ready)
		begin
			status_pending <= 1'b0;
			ready_shown    <= 1'b0;
		end
		else if (show_ready)
			ready_shown <= 1'b1;
	end

	// busy on the next select, ready once the timer has run out
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			q    <= 1'b0;
			q_oe <= 1'b0;
			busy <= 1'b0;
		end
		else
		begin
			q    <= idle && !prog_go;
			q_oe <= cs_sync && status_pending && !drop_ready;
			busy <= !idle || prog_go;
		end
	end

endmodule : eeprom_fill_status_pulse_guard

// ---- eeprom_guard_properties.sv ----
`timescale 1ns/1ps
module guard_checker
#(
	parameter int PROG_CYCLES = 40
)
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// link and status
	input wire logic cs,
	input wire logic q,
	input wire logic q_oe,
	input wire logic busy,
	input wire logic write_enabled
);
	// ----------------
	// busy length
	// ----------------
	int blen;
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			blen <= 0;
		else
			blen <= busy ? blen + 1 : 0;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	busy_len_a: assert property ($fell(busy) |-> blen == PROG_CYCLES + 1)
		else $error("busy length wrong");
	busy_low_a: assert property (q_oe && busy |-> !q)
		else $error("busy not low");
	ready_high_a: assert property (q_oe && !busy && !$past(busy) && !$past(busy, 2) |-> q)
		else $error("ready not high");
	oe_off_a: assert property (!cs [*6] |-> !q_oe)
		else $error("status kept after deselect");
	start_busy_a: assert property ($rose(busy) |-> !$past(cs) && !$past(cs, 2) && !$past(cs, 3))
		else $error("busy before frame end");
	need_enable_a: assert property ($rose(busy) |-> $past(write_enabled))
		else $error("busy while disabled");
	oe_late_a: assert property ($rose(q_oe) |-> $past(cs, 2))
		else $error("status without select");
	busy_stay_a: assert property ($rose(busy) |=> busy [*8])
		else $error("busy cut short");
endmodule : guard_checker

// ---- link_master.sv ----
`timescale 1ns/1ps
module link_master
(
	// serial link toward the device
	output logic link_clk,
	output logic cs,
	output logic d
);
	initial
	begin
		link_clk = 0;
		cs = 0;
		d = 0;
	end
	task automatic set_cs(input logic v);
		cs = v;
	endtask : set_cs
	// clock stands still outside frames
	task automatic frame(input logic [31:0] bits, input int n);
		cs = 1;
		for (int i = n - 1; i >= 0; i--)
		begin
			d = bits[i];
			#15 link_clk = 1;
			#15 link_clk = 0;
		end
		#15 cs = 0;
		d = ~d;
	endtask : frame
endmodule : link_master

// ---- eeprom_fill_status_pulse_guard_bench.sv ----
`timescale 1ns/1ps
module eeprom_fill_status_pulse_guard_bench;
	import eeprom_pkg::*;
	localparam int PC = 20;
	logic sys_clk = 0;
	logic srst = 1;
	logic org = 1;
	logic link_clk, cs, d, q, q_oe, busy, write_enabled;
	int err_count = 0;
	int checks_done = 0;
	int n;
	logic [15:0] rnd = 16'h005b;
	logic [31:0] b;
	logic exp_q[$];
	event look;
	always #12.5 sys_clk = ~sys_clk;
	eeprom_fill_status_pulse_guard #(.PROG_CYCLES(PC)) dut (.sys_clk(sys_clk), .srst(srst),
		.link_clk(link_clk), .cs(cs), .d(d), .q(q), .q_oe(q_oe), .org(org), .busy(busy),
		.write_enabled(write_enabled));
	link_master m (.link_clk(link_clk), .cs(cs), .d(d));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	// k: 0 write, 1 erase, 2 erase-all, 3 fill, 4 enable
	function automatic logic [31:0] mk(input int k, input logic o, input logic [15:0] r,
		output int len);
		int aw, dw;
		logic [8:0] a;
		logic [31:0] v;
		aw = o ? 8 : 9;
		dw = (k == 0 || k == 3) ? (o ? 16 : 8) : 0;
		a = r[8:0];
		if (k >= 2)
			a[aw-1 -: 2] = (k == 2) ? SUB_ERASE_ALL : (k == 3) ? SUB_FILL : SUB_ENABLE;
		v = {30'h0, (k == 0) ? OP_WRITE : (k == 1) ? OP_ERASE : OP_CTRL} | 32'h4;
		for (int i = aw - 1; i >= 0; i--)
			v = {v[30:0], a[i]};
		for (int i = dw - 1; i >= 0; i--)
			v = {v[30:0], r[i]};
		len = 3 + aw + dw;
		return v;
	endfunction : mk
	task automatic check(input string name, input logic exp, input logic got);
		checks_done++;
		if (got !== exp)
		begin
			err_count++;
			$display("Error %s expected %b seen %b", name, exp, got);
		end
	endtask : check
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : tally_and_finish
	// note the outcome, send, look once the fall is seen
	task automatic run(input logic [31:0] bits, input int len, input logic acc);
		exp_q.push_back(acc);
		m.frame(bits, len);
		repeat (8) @(negedge sys_clk);
		->look;
		repeat (PC + 4) @(negedge sys_clk);
	endtask : run
	always @(look)
		check("busy", exp_q.pop_front(), busy);
	initial
	begin
		#1000000;
		err_count++;
		tally_and_finish();
	end
	initial
	begin
		repeat (20) @(negedge sys_clk);
		srst = 0;
		repeat (4) @(negedge sys_clk);
		check("busy", 1'b0, busy);
		check("q_oe", 1'b0, q_oe);
		check("we", 1'b0, write_enabled);
		rnd = lfsr(rnd);
		b = mk(3, 1, rnd, n);
		run(b, n, 0);
		b = mk(4, 1, rnd, n);
		run(b, n, 0);
		check("we", 1'b1, write_enabled);
		for (int o = 1; o >= 0; o--)
		begin
			org = o[0];
			repeat (4) @(negedge sys_clk);
			for (int k = 0; k < 4; k++)
				for (int dl = -1; dl <= 1; dl++)
				begin
					rnd = lfsr(rnd);
					b = mk(k, o[0], rnd, n);
					b = (dl < 0) ? b >> 1 : (dl > 0) ? {b[30:0], rnd[15]} : b;
					run(b, n + dl, dl == 0);
				end
		end
		rnd = lfsr(rnd);
		b = mk(3, 0, rnd, n);
		exp_q.push_back(1);
		m.frame(b, n);
		repeat (8) @(negedge sys_clk);
		->look;
		m.set_cs(1);
		repeat (5) @(negedge sys_clk);
		check("q_oe", 1'b1, q_oe);
		check("q", 1'b0, q);
		repeat (PC + 8) @(negedge sys_clk);
		check("busy", 1'b0, busy);
		check("q", 1'b1, q);
		check("q_oe", 1'b1, q_oe);
		m.set_cs(0);
		repeat (6) @(negedge sys_clk);
		check("q_oe", 1'b0, q_oe);
		// second write starts while the first still programs
		b = mk(0, 0, rnd, n);
		exp_q.push_back(1);
		m.frame(b, n);
		repeat (8) @(negedge sys_clk);
		->look;
		exp_q.push_back(0);
		m.frame(b, n);
		repeat (8) @(negedge sys_clk);
		->look;
		repeat (PC + 4) @(negedge sys_clk);
		tally_and_finish();
	end
endmodule : eeprom_fill_status_pulse_guard_bench
bind eeprom_fill_status_pulse_guard guard_checker #(.PROG_CYCLES(PROG_CYCLES)) chk (
	.sys_clk(sys_clk), .srst(srst), .cs(cs), .q(q), .q_oe(q_oe), .busy(busy),
	.write_enabled(write_enabled));
